// ==== config_bank_pkg.sv ====
// constants for the index/data configuration register bank
// assumes an 8-bit internal i/o bus on the host bus clock
package config_bank_pkg;

    // configuration port pair, chosen by the base-select strap
    localparam logic [15:0] CFG_BASE_PRIMARY   = 16'h002e;
    localparam logic [15:0] CFG_BASE_ALTERNATE = 16'h004e;
    localparam logic [15:0] DATA_PORT_OFFSET   = 16'h0001;

    // register indices
    localparam logic [7:0] IDX_DEVICE_SELECT = 8'h07;
    localparam logic [7:0] IDX_GLOBAL_FIRST  = 8'h20;
    localparam logic [7:0] IDX_GLOBAL_LAST   = 8'h2f;
    localparam logic [7:0] IDX_CHIP_ID       = 8'h20;
    localparam logic [7:0] IDX_CHIP_REV      = 8'h27;
    localparam logic [7:0] IDX_BANK_FIRST    = 8'h30;
    localparam logic [7:0] IDX_ACTIVATE      = 8'h30;
    localparam logic [7:0] IDX_BASE_HIGH     = 8'h60;
    localparam logic [7:0] IDX_BASE_LOW      = 8'h61;
    localparam logic [7:0] IDX_IRQ_NUMBER    = 8'h70;
    localparam logic [7:0] IDX_IRQ_TYPE      = 8'h71;
    localparam logic [7:0] IDX_DMA_FIRST     = 8'h74;
    localparam logic [7:0] IDX_DMA_SECOND    = 8'h75;
    localparam logic [7:0] IDX_VENDOR_FIRST  = 8'hf0;
    localparam logic [7:0] IDX_VENDOR_LAST   = 8'hfe;

    // field positions
    localparam int IRQ_WAKE_BIT  = 4;
    localparam int IRQ_LEVEL_BIT = 0;
    localparam int IRQ_HIGH_BIT  = 1;

    // reset and read-back values
    localparam logic [7:0] INDEX_RESET      = 8'h00;
    localparam logic [7:0] DEVICE_SEL_RESET = 8'h00;
    localparam logic [7:0] UNIMPL_READ      = 8'h00;
    localparam logic [7:0] UNIMPL_DMA_READ  = 8'h04;
    localparam logic [2:0] DMA_NONE         = 3'h4;
    localparam logic [3:0] NO_INTERRUPT_CODE = 4'h0;

    // logical device codes, one bank each
    localparam int NUM_BANKS    = 9;
    localparam int VENDOR_COUNT = 15;
    localparam int GLOBAL_COUNT = 16;
    localparam logic [3:0] BANK_NONE = 4'h9;
    localparam logic [7:0] FLOPPY_CONTROLLER_DEVICE = 8'h00;
    localparam logic [7:0] PRINTER_PORT_DEVICE      = 8'h01;
    localparam logic [7:0] SERIAL_PORT_TWO_INFRARED = 8'h02;
    localparam logic [7:0] SERIAL_PORT_ONE          = 8'h03;
    localparam logic [7:0] GPIO_PORTS_DEVICE        = 8'h07;
    localparam logic [7:0] TIMEOUT_MONITOR_DEVICE   = 8'h0a;
    localparam logic [7:0] JOYSTICK_PORT_DEVICE     = 8'h0b;
    localparam logic [7:0] MIDI_PORT_DEVICE         = 8'h0c;
    localparam logic [7:0] BUS_EXTENSION_DEVICE     = 8'h0f;

endpackage

// ==== config_index_data_bank.sv ====
// index/data configuration register file with per-device banks
// assumes the bus bridge presents one-cycle i/o read/write strobes on clk
// Notes on behaviour
// - strap picks config port pair 2Eh/2Fh or 4Eh/4Fh, caught during reset.
// - index register at base+0, read/write, reads last written, resets to 00h.
// - data port at base+1 reaches whichever register the index selects.
// - global registers below 30h are unbanked, reachable from any bank.
// - indices 30h and up go to the bank chosen by the device select.
// - index 07h selects the bank; nine codes valid, the rest reserved.
// - unimplemented registers ignore writes, read 00h, but 74h/75h read 04h.
// - registers answer right after reset release, with no wait.
// - reserved bits read zero; host uses read-modify-write on them.
// - bit 0 of 30h activates the device; upper bits reserved.
// - inactive bus extension blocks function access yet keeps bridging.
// - 60h/61h hold high and low bytes of the 16-bit base.
// - bit 4 of 70h enables wake-up on the device interrupt, default off.
// - bits 3-0 of 70h pick interrupt 1..15; zero means none.
// - 71h bit 0 edge/level, bit 1 low/high polarity; rest reserved.
// - single-type devices keep a read-only interrupt type register.
// - 74h bits 2-0 pick first dma channel 0..3; 4 means none.
// - 75h picks second dma channel with the same encoding.
// - F0h-FEh hold device-specific option bytes per bank.
// - register values drive each functional block as control signals.
// - bus reset returns every bank and global register to default.
// - base low bits covering the device range are forced zero, read-only.
`timescale 1ns/1ps
`default_nettype none
module config_index_data_bank
    import config_bank_pkg::*;
#(
    // log2 of each bank's i/o range, 3 bits per bank, bank 0 lowest
    parameter logic [NUM_BANKS*3-1:0] BASE_ALIGN_BITS  = {NUM_BANKS{3'h3}},
    parameter logic [NUM_BANKS-1:0]   IRQ_TYPE_FIXED   = '0,
    parameter logic [NUM_BANKS*2-1:0] IRQ_TYPE_DEFAULT = '0,
    parameter logic [NUM_BANKS-1:0]   DMA_FIRST_HAS    = {NUM_BANKS{1'b1}},
    parameter logic [NUM_BANKS-1:0]   DMA_SECOND_HAS   = {NUM_BANKS{1'b1}},
    // identification values are arbitrary
    parameter logic [7:0]             CHIP_ID          = 8'ha5,
    parameter logic [7:0]             CHIP_REV         = 8'h01
) (
    input  wire logic                            clk,
    input  wire logic                            reset,
    input  wire logic                            baseSelectStrap,
    input  wire logic [15:0]                     ioAddr,
    input  wire logic                            ioWrite,
    input  wire logic                            ioRead,
    input  wire logic [7:0]                      ioWdata,
    input  wire logic [NUM_BANKS-1:0]            devIrq,
    output logic      [7:0]                      ioRdata,
    output logic                                 ioRvalid,
    output logic      [NUM_BANKS-1:0]            devActive,
    output logic      [NUM_BANKS-1:0]            devFunctionAccess,
    output logic      [NUM_BANKS*16-1:0]         devBaseAddr,
    output logic      [NUM_BANKS*4-1:0]          devIrqNumber,
    output logic      [NUM_BANKS-1:0]            devIrqWakeEn,
    output logic      [NUM_BANKS-1:0]            devIrqLevel,
    output logic      [NUM_BANKS-1:0]            devIrqHigh,
    output logic      [NUM_BANKS*3-1:0]          devDmaFirst,
    output logic      [NUM_BANKS*3-1:0]          devDmaSecond,
    output logic      [NUM_BANKS*VENDOR_COUNT*8-1:0] devVendorOpts,
    output logic                                 wakeEvent
);

    function automatic logic [3:0] bankOf(input logic [7:0] code);
        logic [3:0] b;
        b = BANK_NONE;
        case (code)
            FLOPPY_CONTROLLER_DEVICE: b = 4'h0;
            PRINTER_PORT_DEVICE:      b = 4'h1;
            SERIAL_PORT_TWO_INFRARED: b = 4'h2;
            SERIAL_PORT_ONE:          b = 4'h3;
            GPIO_PORTS_DEVICE:        b = 4'h4;
            TIMEOUT_MONITOR_DEVICE:   b = 4'h5;
            JOYSTICK_PORT_DEVICE:     b = 4'h6;
            MIDI_PORT_DEVICE:         b = 4'h7;
            BUS_EXTENSION_DEVICE:     b = 4'h8;
            default:                  b = BANK_NONE;
        endcase
        return b;
    endfunction

    // ones over the low base bits that the device decodes itself
    function automatic logic [15:0] alignMask(input int b);
        logic [2:0] bits;
        bits = BASE_ALIGN_BITS[b*3 +: 3];
        return (16'h0001 << bits) - 16'h0001;
    endfunction

    logic             strapMeta_q;
    logic             strapSync_q;
    logic             baseSel_q;
    logic [7:0]       idx_q;
    logic [7:0]       ldn_q;
    logic [7:0]       global_q [GLOBAL_COUNT];
    logic [NUM_BANKS-1:0] active_q;
    logic [15:0]      base_q   [NUM_BANKS];
    logic [3:0]       irqNum_q [NUM_BANKS];
    logic [NUM_BANKS-1:0] wakeEn_q;
    logic [1:0]       irqType_q [NUM_BANKS];
    logic [2:0]       dma0_q   [NUM_BANKS];
    logic [2:0]       dma1_q   [NUM_BANKS];
    logic [7:0]       vendor_q [NUM_BANKS][VENDOR_COUNT];
    logic [NUM_BANKS-1:0] irqPrev_q;
    logic [7:0]       ioRdata_q;
    logic             ioRvalid_q;
    logic             wakeEvent_q;

    logic [15:0]      cfgBase;
    logic             hitIndex;
    logic             hitData;
    logic [3:0]       selBank;
    logic             bankOk;
    logic             dataWr;
    logic             inGlobal;
    logic             globalRo;
    logic             inVendor;
    logic [7:0]       rdData;
    logic [NUM_BANKS-1:0] irqAsserted;
    logic [15:0]      keepMask [NUM_BANKS];

    // strap is a pin: synchronise, then hold whatever it showed while reset was high
    always_ff @(posedge clk) begin
        strapMeta_q <= baseSelectStrap;
        strapSync_q <= strapMeta_q;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            baseSel_q <= strapSync_q;
        end
    end

    assign cfgBase  = baseSel_q ? CFG_BASE_ALTERNATE : CFG_BASE_PRIMARY;
    assign hitIndex = (ioAddr == cfgBase);
    assign hitData  = (ioAddr == cfgBase + DATA_PORT_OFFSET);
    assign dataWr   = ioWrite && hitData;
    assign selBank  = bankOf(ldn_q);
    assign bankOk   = (selBank != BANK_NONE) && (idx_q >= IDX_BANK_FIRST);
    assign inGlobal = (idx_q >= IDX_GLOBAL_FIRST) && (idx_q <= IDX_GLOBAL_LAST);
    assign globalRo = (idx_q == IDX_CHIP_ID) || (idx_q == IDX_CHIP_REV);
    assign inVendor = (idx_q >= IDX_VENDOR_FIRST) && (idx_q <= IDX_VENDOR_LAST);

    // index only moves on a write to base+0, never on data accesses
    always_ff @(posedge clk) begin
        if (reset) begin
            idx_q <= INDEX_RESET;
        end else if (ioWrite && hitIndex) begin
            idx_q <= ioWdata;
        end
    end

    // device select stores any code; reserved codes leave banked space unmapped
    always_ff @(posedge clk) begin
        if (reset) begin
            ldn_q <= DEVICE_SEL_RESET;
        end else if (dataWr && idx_q == IDX_DEVICE_SELECT) begin
            ldn_q <= ioWdata;
        end
    end

    // unbanked global storage; id and revision slots are read-only
    always_ff @(posedge clk) begin
        if (reset) begin
            for (int g = 0; g < GLOBAL_COUNT; g++) begin
                global_q[g] <= 8'h00;
            end
        end else if (dataWr && inGlobal && !globalRo) begin
            global_q[idx_q[3:0]] <= ioWdata;
        end
    end

    // banked registers; writes to holes fall through and are dropped
    always_ff @(posedge clk) begin
        if (reset) begin
            for (int b = 0; b < NUM_BANKS; b++) begin
                active_q[b]  <= 1'b0;
                base_q[b]    <= 16'h0000;
                irqNum_q[b]  <= NO_INTERRUPT_CODE;
                wakeEn_q[b]  <= 1'b0;
                irqType_q[b] <= IRQ_TYPE_DEFAULT[b*2 +: 2];
                dma0_q[b]    <= DMA_NONE;
                dma1_q[b]    <= DMA_NONE;
                for (int v = 0; v < VENDOR_COUNT; v++) begin
                    vendor_q[b][v] <= 8'h00;
                end
            end
        end else if (dataWr && bankOk) begin
            for (int b = 0; b < NUM_BANKS; b++) begin
                if (b == int'(selBank)) begin
                    if (idx_q == IDX_ACTIVATE) begin
                        active_q[b] <= ioWdata[0];
                    end
                    if (idx_q == IDX_BASE_HIGH) begin
                        base_q[b][15:8] <= ioWdata & keepMask[b][15:8];
                    end
                    if (idx_q == IDX_BASE_LOW) begin
                        base_q[b][7:0] <= ioWdata & keepMask[b][7:0];
                    end
                    if (idx_q == IDX_IRQ_NUMBER) begin
                        irqNum_q[b] <= ioWdata[3:0];
                        wakeEn_q[b] <= ioWdata[IRQ_WAKE_BIT];
                    end
                    if (idx_q == IDX_IRQ_TYPE && !IRQ_TYPE_FIXED[b]) begin
                        irqType_q[b] <= {ioWdata[IRQ_HIGH_BIT], ioWdata[IRQ_LEVEL_BIT]};
                    end
                    // reserved codes 5-7 are stored as written; the block treats them as none
                    if (idx_q == IDX_DMA_FIRST && DMA_FIRST_HAS[b]) begin
                        dma0_q[b] <= ioWdata[2:0];
                    end
                    if (idx_q == IDX_DMA_SECOND && DMA_SECOND_HAS[b]) begin
                        dma1_q[b] <= ioWdata[2:0];
                    end
                    if (inVendor) begin
                        vendor_q[b][idx_q[3:0]] <= ioWdata;
                    end
                end
            end
        end
    end

    // read path: reserved bits come back as zero
    always_comb begin
        rdData = ((idx_q == IDX_DMA_FIRST) || (idx_q == IDX_DMA_SECOND))
               ? UNIMPL_DMA_READ : UNIMPL_READ;
        if (idx_q == IDX_DEVICE_SELECT) begin
            rdData = ldn_q;
        end else if (idx_q == IDX_CHIP_ID) begin
            rdData = CHIP_ID;
        end else if (idx_q == IDX_CHIP_REV) begin
            rdData = CHIP_REV;
        end else if (inGlobal) begin
            rdData = global_q[idx_q[3:0]];
        end else if (bankOk) begin
            if (idx_q == IDX_ACTIVATE) begin
                rdData = {7'h00, active_q[selBank]};
            end else if (idx_q == IDX_BASE_HIGH) begin
                rdData = base_q[selBank][15:8];
            end else if (idx_q == IDX_BASE_LOW) begin
                rdData = base_q[selBank][7:0];
            end else if (idx_q == IDX_IRQ_NUMBER) begin
                rdData = {3'h0, wakeEn_q[selBank], irqNum_q[selBank]};
            end else if (idx_q == IDX_IRQ_TYPE) begin
                rdData = {6'h00, irqType_q[selBank]};
            end else if (idx_q == IDX_DMA_FIRST && DMA_FIRST_HAS[selBank]) begin
                rdData = {5'h00, dma0_q[selBank]};
            end else if (idx_q == IDX_DMA_SECOND && DMA_SECOND_HAS[selBank]) begin
                rdData = {5'h00, dma1_q[selBank]};
            end else if (inVendor) begin
                rdData = vendor_q[selBank][idx_q[3:0]];
            end
        end
    end

    // answer one cycle after the strobe, from the first cycle out of reset
    always_ff @(posedge clk) begin
        if (reset) begin
            ioRdata_q  <= 8'h00;
            ioRvalid_q <= 1'b0;
        end else begin
            ioRvalid_q <= ioRead && (hitIndex || hitData);
            if (ioRead && hitIndex) begin
                ioRdata_q <= idx_q;
            end else if (ioRead && hitData) begin
                ioRdata_q <= rdData;
            end
        end
    end

    // wake-up: a fresh assertion of an enabled device interrupt, polarity-aware
    assign irqAsserted = devIrq ~^ devIrqHigh;

    always_ff @(posedge clk) begin
        if (reset) begin
            irqPrev_q   <= '0;
            wakeEvent_q <= 1'b0;
        end else begin
            irqPrev_q   <= irqAsserted;
            wakeEvent_q <= |(irqAsserted & ~irqPrev_q & wakeEn_q);
        end
    end

    // control fan-out; deactivation only gates host access, so bridging that
    // reads base and option values keeps running while the device is off
    for (genvar b = 0; b < NUM_BANKS; b++) begin : g_out
        // bits the base register may hold; fixed per bank, so no logic per write
        assign keepMask[b] = ~alignMask(b);
        assign devBaseAddr[b*16 +: 16] = base_q[b];
        assign devIrqNumber[b*4 +: 4]  = irqNum_q[b];
        assign devIrqLevel[b]          = irqType_q[b][0];
        assign devIrqHigh[b]           = irqType_q[b][1];
        assign devDmaFirst[b*3 +: 3]   = dma0_q[b];
        assign devDmaSecond[b*3 +: 3]  = dma1_q[b];
        for (genvar v = 0; v < VENDOR_COUNT; v++) begin : g_vend
            assign devVendorOpts[(b*VENDOR_COUNT+v)*8 +: 8] = vendor_q[b][v];
        end
    end
    assign devActive         = active_q;
    assign devFunctionAccess = active_q;
    assign devIrqWakeEn      = wakeEn_q;
    assign ioRdata           = ioRdata_q;
    assign ioRvalid          = ioRvalid_q;
    assign wakeEvent         = wakeEvent_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // the sync flops start unknown, so compare only after three reset edges
    a_strap_capture: assert property (disable iff (1'b0)
        reset [*3] ##1 reset |-> baseSel_q == $past(strapSync_q))
        else $error("strap value not captured during reset");
    a_index_readback: assert property (ioWrite && hitIndex ##1 !(ioWrite && hitIndex)
        ##1 ioRead && hitIndex && !ioWrite |=> ioRvalid && ioRdata == $past(ioWdata, 3))
        else $error("index read does not return last write");
    a_index_steady: assert property ((ioRead || ioWrite) && hitData && !hitIndex
        |=> $stable(idx_q))
        else $error("index moved on a data access");
    a_hole_zero: assert property (ioRead && hitData && idx_q < IDX_GLOBAL_FIRST
        && idx_q != IDX_DEVICE_SELECT |=> ioRdata == UNIMPL_READ)
        else $error("unimplemented register read not zero");
    a_hole_dma: assert property (ioRead && hitData
        && (idx_q == IDX_DMA_FIRST || idx_q == IDX_DMA_SECOND)
        && selBank == BANK_NONE |=> ioRdata == UNIMPL_DMA_READ)
        else $error("unmapped dma select read not 04h");
    a_read_answer: assert property (ioRead && (hitIndex || hitData) |=> ioRvalid ##1 !ioRvalid
        || $past(ioRead))
        else $error("read answer missing or stretched");
    a_activate_write: assert property (dataWr && bankOk && idx_q == IDX_ACTIVATE
        |=> devActive[$past(selBank)] == $past(ioWdata[0]))
        else $error("activate bit not updated");
    a_base_aligned: assert property (dataWr && bankOk && idx_q == IDX_BASE_LOW
        |=> (base_q[$past(selBank)] & alignMask(int'($past(selBank)))) == 16'h0000)
        else $error("base low bits not forced to zero");
    a_type_locked: assert property (dataWr && bankOk && idx_q == IDX_IRQ_TYPE
        && IRQ_TYPE_FIXED[selBank] |=> $stable(irqType_q[$past(selBank)]))
        else $error("read-only interrupt type changed");
    a_wake_pulse: assert property (|(irqAsserted & ~irqPrev_q & wakeEn_q) |=> wakeEvent)
        else $error("enabled interrupt raised no wake event");
    a_wake_cause: assert property (wakeEvent |-> $past(|(wakeEn_q & irqAsserted)))
        else $error("wake event without enabled interrupt");

    // write paths land in the addressed register one cycle after the strobe
    a_select_write: assert property (dataWr && idx_q == IDX_DEVICE_SELECT
        |=> ldn_q == $past(ioWdata))
        else $error("device select not updated");
    a_global_write: assert property (dataWr && inGlobal && !globalRo
        |=> global_q[$past(idx_q[3:0])] == $past(ioWdata))
        else $error("global register not updated");
    a_irq_number: assert property (dataWr && bankOk && idx_q == IDX_IRQ_NUMBER
        |=> irqNum_q[$past(selBank)] == $past(ioWdata[3:0]))
        else $error("interrupt number not updated");
    a_type_write: assert property (dataWr && bankOk && idx_q == IDX_IRQ_TYPE
        && !IRQ_TYPE_FIXED[selBank] |=> irqType_q[$past(selBank)]
        == {$past(ioWdata[IRQ_HIGH_BIT]), $past(ioWdata[IRQ_LEVEL_BIT])})
        else $error("interrupt type not updated");
    a_dma_write: assert property (dataWr && bankOk && idx_q == IDX_DMA_FIRST
        && DMA_FIRST_HAS[selBank] |=> dma0_q[$past(selBank)] == $past(ioWdata[2:0]))
        else $error("first dma select not updated");
    a_vendor_write: assert property (dataWr && bankOk && inVendor
        |=> vendor_q[$past(selBank)][$past(idx_q[3:0])] == $past(ioWdata))
        else $error("option byte not updated");
    a_reserved_drop: assert property (dataWr && idx_q >= IDX_BANK_FIRST && !bankOk
        |=> $stable(active_q) && $stable(wakeEn_q))
        else $error("write to unmapped bank changed state");
    // reset must win over any strobe in the same cycle
    a_reset_clear: assert property (disable iff (1'b0) reset
        |=> idx_q == INDEX_RESET && ldn_q == DEVICE_SEL_RESET && active_q == '0
        && !ioRvalid && !wakeEvent)
        else $error("registers not back at reset values");

    c_index_then_data: cover property (ioWrite && hitIndex ##1 ioRead && hitData);
    c_bank_switch: cover property (dataWr && idx_q == IDX_DEVICE_SELECT ##[1:4] ioRead && hitData);
    c_wake: cover property (wakeEvent);
    c_hole_dma: cover property (ioRead && hitData && idx_q == IDX_DMA_FIRST && !bankOk);
    c_type_locked: cover property (dataWr && bankOk && idx_q == IDX_IRQ_TYPE
        && IRQ_TYPE_FIXED[selBank]);

endmodule
`default_nettype wire

// ==== io_host_model.sv ====
// host side of the configuration port: one-cycle i/o read and write strobes
// assumes the bank answers a read with ioRvalid one cycle after the strobe edge
`timescale 1ns/1ps
`default_nettype none
module io_host_model (
    input  wire logic        clk,
    input  wire logic [7:0]  ioRdata,
    input  wire logic        ioRvalid,
    output logic      [15:0] ioAddr,
    output logic             ioWrite,
    output logic             ioRead,
    output logic      [7:0]  ioWdata
);
    initial begin
        ioAddr = 16'h0000;
        ioWrite = 1'b0;
        ioRead = 1'b0;
        ioWdata = 8'h00;
    end
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        ioAddr <= a;
        ioWdata <= d;
        ioWrite <= 1'b1;
        @(posedge clk);
        ioWrite <= 1'b0;
        // released data must not keep looking valid
        ioWdata <= ~d;
        // let the written register settle before the caller looks at outputs
        #1;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic v);
        @(posedge clk);
        ioAddr <= a;
        ioRead <= 1'b1;
        @(posedge clk);
        ioRead <= 1'b0;
        #1;
        v = ioRvalid;
        d = ioRdata;
    endtask
    // set bits without disturbing reserved ones
    task automatic rmw(input logic [15:0] a, input logic [7:0] setMask);
        logic [7:0] d;
        logic       v;
        rd(a, d, v);
        wr(a, d | setMask);
    endtask
endmodule
`default_nettype wire

// ==== config_index_data_bank_bench.sv ====
// self-checking bench for the index/data configuration bank
// assumes default parameters (8-byte aligned bases, all dma selects present),
// except that bank 8 has a fixed interrupt type
`timescale 1ns/1ps
`default_nettype none
module config_index_data_bank_bench;
    import config_bank_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic strap = 1'b0;
    logic [NUM_BANKS-1:0] devIrq = '0;
    logic [15:0] ioAddr, base;
    logic ioWrite, ioRead, ioRvalid, wakeEvent;
    logic [7:0] ioWdata, ioRdata, d;
    logic v;
    logic [NUM_BANKS-1:0] act, fAcc, wakeEn, lvl, high;
    logic [NUM_BANKS*16-1:0] bases;
    logic [NUM_BANKS*4-1:0] irqNum;
    logic [NUM_BANKS*3-1:0] dma0, dma1;
    logic [NUM_BANKS*VENDOR_COUNT*8-1:0] vend;
    int failures = 0;
    int n_checks = 0;
    logic [7:0] codes [NUM_BANKS] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h07, 8'h0a, 8'h0b,
                                      8'h0c, 8'h0f};
    always #2 clk = ~clk;
    config_index_data_bank #(.IRQ_TYPE_FIXED(9'h100)) dut (.clk(clk), .reset(reset),
        .baseSelectStrap(strap),
        .ioAddr(ioAddr), .ioWrite(ioWrite), .ioRead(ioRead), .ioWdata(ioWdata),
        .devIrq(devIrq), .ioRdata(ioRdata), .ioRvalid(ioRvalid), .devActive(act),
        .devFunctionAccess(fAcc), .devBaseAddr(bases), .devIrqNumber(irqNum),
        .devIrqWakeEn(wakeEn), .devIrqLevel(lvl), .devIrqHigh(high), .devDmaFirst(dma0),
        .devDmaSecond(dma1), .devVendorOpts(vend), .wakeEvent(wakeEvent));
    io_host_model host (.clk(clk), .ioRdata(ioRdata), .ioRvalid(ioRvalid),
        .ioAddr(ioAddr), .ioWrite(ioWrite), .ioRead(ioRead), .ioWdata(ioWdata));
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic cw(input logic [7:0] idx, input logic [7:0] val);
        host.wr(base, idx);
        host.wr(base + 16'h0001, val);
    endtask
    task automatic cr(input logic [7:0] idx, input logic [7:0] exp);
        host.wr(base, idx);
        host.rd(base + 16'h0001, d, v);
        chk({7'h00, v, d}, {8'h01, exp});
    endtask
    task automatic doReset(input logic s);
        @(posedge clk);
        strap <= s;
        reset <= 1'b1;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        base = s ? CFG_BASE_ALTERNATE : CFG_BASE_PRIMARY;
    endtask
    initial begin
        #200000;
        failures++;
        final_report();
    end
    initial begin
        doReset(1'b0);
        host.rd(base, d, v);
        chk({7'h00, v, d}, 16'h0100);
        chk({act, dma0}, {9'h000, {NUM_BANKS{3'h4}}});
        cr(8'h74, 8'h04);
        cr(8'h75, 8'h04);
        host.wr(base, 8'h5a);
        host.rd(base, d, v);
        chk(d, 8'h5a);
        cw(8'h21, 8'h3c);
        for (int b = 0; b < NUM_BANKS; b++) begin
            cw(IDX_DEVICE_SELECT, codes[b]);
            cr(IDX_DEVICE_SELECT, codes[b]);
            cr(8'h21, 8'h3c);
            cw(8'h30, 8'hff);
            cr(8'h30, 8'h01);
            cw(8'h60, 8'h12);
            cw(8'h61, 8'h37 + 8'(b));
            cr(8'h61, (8'h37 + 8'(b)) & 8'hf8);
            cw(8'h74, 8'(b % 4));
            cw(8'h75, 8'hff);
            cw(8'hf0 + 8'(b), 8'h80 | 8'(b));
            chk(bases[b*16+:16], {8'h12, (8'h37 + 8'(b)) & 8'hf8});
            chk({dma0[b*3+:3], dma1[b*3+:3]}, {3'(b % 4), 3'h7});
            chk(vend[(b*15+b)*8+:8], 8'h80 | 8'(b));
        end
        cr(8'h75, 8'h07);
        cw(8'h71, 8'h03);
        cr(8'h71, 8'h00);
        chk({act, fAcc}, {9'h1ff, 9'h1ff});
        cw(8'h30, 8'h00);
        chk({fAcc[8], bases[8*16+:16]}, {1'b0, 16'h1238});
        cw(8'hfe, 8'h99);
        cr(8'hfe, 8'h99);
        host.rd(base + 16'h0001, d, v);
        chk(d, 8'h99);
        cw(8'h62, 8'h55);
        cr(8'h62, 8'h00);
        cr(8'h08, 8'h00);
        cw(IDX_DEVICE_SELECT, 8'h05);
        cw(8'h30, 8'h01);
        cr(8'h30, 8'h00);
        cr(8'h74, 8'h04);
        cw(IDX_DEVICE_SELECT, 8'h00);
        cw(8'h71, 8'hff);
        cr(8'h71, 8'h03);
        cw(8'h71, 8'h02);
        cw(8'h70, 8'he5);
        cr(8'h70, 8'h05);
        host.rmw(base + 16'h0001, 8'h10);
        chk({irqNum[3:0], wakeEn[0], lvl[0], high[0]}, {4'h5, 3'b101});
        @(posedge clk);
        devIrq[0] <= 1'b1;
        v = 1'b0;
        for (int i = 0; i < 4 && !v; i++) begin
            @(posedge clk);
            #1;
            v = (wakeEvent === 1'b1);
        end
        chk(v, 1'b1);
        @(posedge clk);
        #1;
        chk(wakeEvent, 1'b0);
        doReset(1'b1);
        host.rd(16'h002e, d, v);
        chk(v, 1'b0);
        cr(8'h70, 8'h00);
        chk({act, wakeEn, irqNum[3:0]}, 22'h0);
        final_report();
    end
endmodule
`default_nettype wire
